//--- aig_defs.svh
// register map, field positions and reset values of the anti-pop and input gain bank
//Contract
// - ramp speed field bits 9:8, resets 00
// - bits 7:6 set line four discharge rate
// - bits 5:4 set line three discharge rate
// - bits 3:2 set headphone pair two rate
// - bits 1:0 set headphone pair one rate
// - left bit 15 enables left amp, resets 0
// - left bit 14 mutes and disconnects left amp
// - left bit 13 defers gain to zero cross
// - gains pend until bit 8 written one
// - left gain code bits 7:2, resets 010000
// - right bit 15 enables right amp, resets 0
// - right bit 14 mutes and disconnects right amp
// - right bit 13 defers gain to zero cross
// - right gain code bits 7:2, same scale
`ifndef AIG_DEFS_SVH
`define AIG_DEFS_SVH

// register offsets
`define AIG_ADDR_ANTIPOP 8'h4E
`define AIG_ADDR_LEFT 8'h50
`define AIG_ADDR_RIGHT 8'h51

// anti-pop field positions
`define AIG_RAMP_HI 9
`define AIG_RAMP_LO 8
`define AIG_LN4_HI 7
`define AIG_LN4_LO 6
`define AIG_LN3_HI 5
`define AIG_LN3_LO 4
`define AIG_HP2_HI 3
`define AIG_HP2_LO 2
`define AIG_HP1_HI 1
`define AIG_HP1_LO 0

// input gain field positions
`define AIG_ENA_BIT 15
`define AIG_MUTE_BIT 14
`define AIG_ZC_BIT 13
`define AIG_VU_BIT 8
`define AIG_GAIN_HI 7
`define AIG_GAIN_LO 2

// reset values
`define AIG_RST_RATE 2'h0
`define AIG_RST_GAIN 6'h10
`define AIG_RST_BIT 1'h0
`define AIG_RATE_OFF 2'h0

`endif

//--- aig_pkg.sv
// types shared by the anti-pop and input gain bank
package aig_pkg;

  // software view of one input gain channel
  typedef struct packed {
    logic       ena;
    logic       mute;
    logic       zc;
    logic [5:0] gain;
  } ch_cfg_t;

  // gain update sequencing per channel
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } ch_state_t;

endpackage

//--- aig_regs.sv
// anti-pop discharge control and input gain register bank
`timescale 1ns/1ps
`default_nettype none
`include "aig_defs.svh"

module aig_regs (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // zero-cross detector pulses
  input wire logic ZC_LEFT_I,
  input wire logic ZC_RIGHT_I,
  // reference ramp and discharge controls
  output logic [1:0] RAMP_SPEED_O,
  output logic RAMP_ENA_O,
  output logic [1:0] LN4_DIS_RATE_O,
  output logic LN4_DIS_ENA_O,
  output logic [1:0] LN3_DIS_RATE_O,
  output logic LN3_DIS_ENA_O,
  output logic [1:0] HP2_DIS_RATE_O,
  output logic HP2_DIS_ENA_O,
  output logic [1:0] HP1_DIS_RATE_O,
  output logic HP1_DIS_ENA_O,
  // left input gain amplifier
  output logic LEFT_AMP_ENA_O,
  output logic LEFT_AMP_MUTE_O,
  output logic LEFT_MIX_CONNECT_O,
  output logic [5:0] LEFT_GAIN_O,
  // right input gain amplifier
  output logic RIGHT_AMP_ENA_O,
  output logic RIGHT_AMP_MUTE_O,
  output logic RIGHT_MIX_CONNECT_O,
  output logic [5:0] RIGHT_GAIN_O
);

  // code 00 means the path or ramp is off
  function automatic logic rate_active(input logic [1:0] code);
    rate_active = (code != `AIG_RATE_OFF);
  endfunction

  // anti-pop register state
  logic [1:0] ramp_r, ramp_nxt;
  logic [1:0] ln4_r, ln4_nxt;
  logic [1:0] ln3_r, ln3_nxt;
  logic [1:0] hp2_r, hp2_nxt;
  logic [1:0] hp1_r, hp1_nxt;

  // written (pending) channel config, index 0 left, 1 right
  aig_pkg::ch_cfg_t cfg_r [2];
  aig_pkg::ch_cfg_t cfg_nxt [2];
  // gain captured at the update trigger, waiting for its crossing
  logic [5:0] armed_r [2];
  logic [5:0] armed_nxt [2];
  // gain actually driving the amplifier
  logic [5:0] active_r [2];
  logic [5:0] active_nxt [2];
  aig_pkg::ch_state_t state_r [2];
  aig_pkg::ch_state_t state_nxt [2];

  // read port next values; the data output flop itself holds between reads
  logic [15:0] rdata_nxt;
  logic rvalid_nxt;

  // decoded write strobes
  logic wr_ap, wr_left, wr_right, trigger;
  logic [1:0] wr_ch;
  logic [1:0] zc_in;

  assign wr_ap = REG_WR_I && (REG_ADDR_I == `AIG_ADDR_ANTIPOP);
  assign wr_left = REG_WR_I && (REG_ADDR_I == `AIG_ADDR_LEFT);
  assign wr_right = REG_WR_I && (REG_ADDR_I == `AIG_ADDR_RIGHT);
  assign wr_ch = {wr_right, wr_left};
  // one write with bit 8 set to either gain register latches both channels
  assign trigger = (wr_left || wr_right) && REG_WDATA_I[`AIG_VU_BIT];
  assign zc_in = {ZC_RIGHT_I, ZC_LEFT_I};

  // anti-pop field next values
  always_comb begin
    ramp_nxt = ramp_r;
    ln4_nxt = ln4_r;
    ln3_nxt = ln3_r;
    hp2_nxt = hp2_r;
    hp1_nxt = hp1_r;
    if (wr_ap) begin
      ramp_nxt = REG_WDATA_I[`AIG_RAMP_HI:`AIG_RAMP_LO];
      ln4_nxt = REG_WDATA_I[`AIG_LN4_HI:`AIG_LN4_LO];
      ln3_nxt = REG_WDATA_I[`AIG_LN3_HI:`AIG_LN3_LO];
      hp2_nxt = REG_WDATA_I[`AIG_HP2_HI:`AIG_HP2_LO];
      hp1_nxt = REG_WDATA_I[`AIG_HP1_HI:`AIG_HP1_LO];
    end
  end

  // anti-pop field registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ramp_r <= `AIG_RST_RATE;
      ln4_r <= `AIG_RST_RATE;
      ln3_r <= `AIG_RST_RATE;
      hp2_r <= `AIG_RST_RATE;
      hp1_r <= `AIG_RST_RATE;
    end else begin
      ramp_r <= ramp_nxt;
      ln4_r <= ln4_nxt;
      ln3_r <= ln3_nxt;
      hp2_r <= hp2_nxt;
      hp1_r <= hp1_nxt;
    end
  end

  // per-channel config, trigger capture and zero-cross sequencing
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cfg_nxt[c] = cfg_r[c];
      armed_nxt[c] = armed_r[c];
      active_nxt[c] = active_r[c];
      state_nxt[c] = state_r[c];
      // enable and mute act at once; only the gain is held back
      if (wr_ch[c]) begin
        cfg_nxt[c].ena = REG_WDATA_I[`AIG_ENA_BIT];
        cfg_nxt[c].mute = REG_WDATA_I[`AIG_MUTE_BIT];
        cfg_nxt[c].zc = REG_WDATA_I[`AIG_ZC_BIT];
        cfg_nxt[c].gain = REG_WDATA_I[`AIG_GAIN_HI:`AIG_GAIN_LO];
      end
      case (state_r[c])
        aig_pkg::ST_IDLE: begin
          if (trigger) begin
            armed_nxt[c] = cfg_nxt[c].gain;
            if (cfg_nxt[c].zc) begin
              // wait for the next crossing to avoid a zipper click
              state_nxt[c] = aig_pkg::ST_WAIT;
            end else begin
              active_nxt[c] = cfg_nxt[c].gain;
            end
          end
        end
        aig_pkg::ST_WAIT: begin
          if (trigger) begin
            // a fresh trigger replaces the armed value; a crossing in
            // the same cycle applies the fresh value so neither is lost
            armed_nxt[c] = cfg_nxt[c].gain;
            if (zc_in[c] || !cfg_nxt[c].zc) begin
              active_nxt[c] = cfg_nxt[c].gain;
              state_nxt[c] = aig_pkg::ST_IDLE;
            end
          end else if (zc_in[c]) begin
            active_nxt[c] = armed_r[c];
            state_nxt[c] = aig_pkg::ST_IDLE;
          end else if (!cfg_r[c].zc) begin
            // zero-cross turned off while waiting: stop waiting one cycle after the clearing write
            active_nxt[c] = armed_r[c];
            state_nxt[c] = aig_pkg::ST_IDLE;
          end
        end
        default: begin
          state_nxt[c] = aig_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // per-channel registers, one instance per channel
  for (genvar g = 0; g < 2; g++) begin : g_ch
    always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
        cfg_r[g].ena <= `AIG_RST_BIT;
        cfg_r[g].mute <= `AIG_RST_BIT;
        cfg_r[g].zc <= `AIG_RST_BIT;
        cfg_r[g].gain <= `AIG_RST_GAIN;
        armed_r[g] <= `AIG_RST_GAIN;
        active_r[g] <= `AIG_RST_GAIN;
        state_r[g] <= aig_pkg::ST_IDLE;
      end else begin
        cfg_r[g] <= cfg_nxt[g];
        armed_r[g] <= armed_nxt[g];
        active_r[g] <= active_nxt[g];
        state_r[g] <= state_nxt[g];
      end
    end
  end

  // readback: pending gain, trigger bit reads zero, unmapped reads zero
  always_comb begin
    rdata_nxt = REG_RDATA_O;
    rvalid_nxt = REG_RD_I;
    if (REG_RD_I) begin
      rdata_nxt = 16'h0000;
      case (REG_ADDR_I)
        `AIG_ADDR_ANTIPOP: begin
          rdata_nxt[`AIG_RAMP_HI:`AIG_RAMP_LO] = ramp_r;
          rdata_nxt[`AIG_LN4_HI:`AIG_LN4_LO] = ln4_r;
          rdata_nxt[`AIG_LN3_HI:`AIG_LN3_LO] = ln3_r;
          rdata_nxt[`AIG_HP2_HI:`AIG_HP2_LO] = hp2_r;
          rdata_nxt[`AIG_HP1_HI:`AIG_HP1_LO] = hp1_r;
        end
        `AIG_ADDR_LEFT, `AIG_ADDR_RIGHT: begin
          rdata_nxt[`AIG_ENA_BIT] = cfg_r[REG_ADDR_I[0]].ena;
          rdata_nxt[`AIG_MUTE_BIT] = cfg_r[REG_ADDR_I[0]].mute;
          rdata_nxt[`AIG_ZC_BIT] = cfg_r[REG_ADDR_I[0]].zc;
          rdata_nxt[`AIG_GAIN_HI:`AIG_GAIN_LO] = cfg_r[REG_ADDR_I[0]].gain;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  // output flops; decodes are registered so every output is a flop
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RAMP_SPEED_O <= `AIG_RST_RATE;
      RAMP_ENA_O <= 1'b0;
      LN4_DIS_RATE_O <= `AIG_RST_RATE;
      LN4_DIS_ENA_O <= 1'b0;
      LN3_DIS_RATE_O <= `AIG_RST_RATE;
      LN3_DIS_ENA_O <= 1'b0;
      HP2_DIS_RATE_O <= `AIG_RST_RATE;
      HP2_DIS_ENA_O <= 1'b0;
      HP1_DIS_RATE_O <= `AIG_RST_RATE;
      HP1_DIS_ENA_O <= 1'b0;
      LEFT_AMP_ENA_O <= 1'b0;
      LEFT_AMP_MUTE_O <= 1'b0;
      LEFT_MIX_CONNECT_O <= 1'b0;
      LEFT_GAIN_O <= `AIG_RST_GAIN;
      RIGHT_AMP_ENA_O <= 1'b0;
      RIGHT_AMP_MUTE_O <= 1'b0;
      RIGHT_MIX_CONNECT_O <= 1'b0;
      RIGHT_GAIN_O <= `AIG_RST_GAIN;
      REG_RDATA_O <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      RAMP_SPEED_O <= ramp_nxt;
      RAMP_ENA_O <= rate_active(ramp_nxt);
      LN4_DIS_RATE_O <= ln4_nxt;
      LN4_DIS_ENA_O <= rate_active(ln4_nxt);
      LN3_DIS_RATE_O <= ln3_nxt;
      LN3_DIS_ENA_O <= rate_active(ln3_nxt);
      HP2_DIS_RATE_O <= hp2_nxt;
      HP2_DIS_ENA_O <= rate_active(hp2_nxt);
      HP1_DIS_RATE_O <= hp1_nxt;
      HP1_DIS_ENA_O <= rate_active(hp1_nxt);
      LEFT_AMP_ENA_O <= cfg_nxt[0].ena;
      LEFT_AMP_MUTE_O <= cfg_nxt[0].mute;
      LEFT_MIX_CONNECT_O <= cfg_nxt[0].ena && !cfg_nxt[0].mute;
      LEFT_GAIN_O <= active_nxt[0];
      RIGHT_AMP_ENA_O <= cfg_nxt[1].ena;
      RIGHT_AMP_MUTE_O <= cfg_nxt[1].mute;
      RIGHT_MIX_CONNECT_O <= cfg_nxt[1].ena && !cfg_nxt[1].mute;
      RIGHT_GAIN_O <= active_nxt[1];
      REG_RDATA_O <= rdata_nxt;
      REG_RVALID_O <= rvalid_nxt;
    end
  end

endmodule

`default_nettype wire

//--- aig_regs_sva.sv
// concurrent checks on the ports of the anti-pop and input gain bank
`timescale 1ns/1ps
`default_nettype none
`include "aig_defs.svh"
module aig_regs_sva (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_RVALID_O,
  // watched controls
  input wire logic ZC_LEFT_I,
  input wire logic [1:0] RAMP_SPEED_O,
  input wire logic RAMP_ENA_O,
  input wire logic [1:0] LN4_DIS_RATE_O,
  input wire logic [1:0] HP1_DIS_RATE_O,
  input wire logic LEFT_AMP_ENA_O,
  input wire logic LEFT_AMP_MUTE_O,
  input wire logic LEFT_MIX_CONNECT_O,
  input wire logic [5:0] LEFT_GAIN_O,
  input wire logic [5:0] RIGHT_GAIN_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // write strobes decoded per register
  logic wr_ap;
  logic wr_l;
  logic wr_r;
  assign wr_ap = REG_WR_I && (REG_ADDR_I == `AIG_ADDR_ANTIPOP);
  assign wr_l = REG_WR_I && (REG_ADDR_I == `AIG_ADDR_LEFT);
  assign wr_r = REG_WR_I && (REG_ADDR_I == `AIG_ADDR_RIGHT);
  // read answer exactly one cycle later, never unasked
  chk_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered in one cycle");
  chk_rvalid_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("read valid without a read");
  // anti-pop fields follow the written word
  chk_ramp_code: assert property (wr_ap |=> RAMP_SPEED_O == $past(REG_WDATA_I[9:8])
    && RAMP_ENA_O == ($past(REG_WDATA_I[9:8]) != 2'h0)) else $error("ramp code wrong");
  chk_ln4_rate: assert property (wr_ap |=> LN4_DIS_RATE_O == $past(REG_WDATA_I[7:6]))
    else $error("line four rate wrong");
  chk_hp1_rate: assert property (wr_ap |=> HP1_DIS_RATE_O == $past(REG_WDATA_I[1:0]))
    else $error("pair one rate wrong");
  // enable and mute take effect at once
  chk_left_ctrl: assert property (wr_l |=>
    LEFT_AMP_ENA_O == $past(REG_WDATA_I[15]) && LEFT_AMP_MUTE_O == $past(REG_WDATA_I[14]))
    else $error("left enable or mute wrong");
  // mixer link follows the written enable and mute, not the output flops
  chk_mix_connect: assert property (wr_l |=>
    LEFT_MIX_CONNECT_O == ($past(REG_WDATA_I[15]) && !$past(REG_WDATA_I[14])))
    else $error("left mixer connect wrong");
  // active gain moves only on a gain write or a crossing; clearing the
  // zero-cross bit while waiting releases the armed gain one cycle late
  chk_gain_cause: assert property ($changed(LEFT_GAIN_O) |->
    $past(wr_l || wr_r || ZC_LEFT_I) || $past(wr_l, 2))
    else $error("left gain changed without cause");
  // trigger with zero cross off applies at once
  chk_right_now: assert property (wr_r && REG_WDATA_I[8] && !REG_WDATA_I[13]
    |=> RIGHT_GAIN_O == $past(REG_WDATA_I[7:2])) else $error("right gain not applied");
endmodule
bind aig_regs aig_regs_sva u_sva (
  .CLK_I(CLK_I),
  .RST_I(RST_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_RVALID_O(REG_RVALID_O),
  .ZC_LEFT_I(ZC_LEFT_I),
  .RAMP_SPEED_O(RAMP_SPEED_O),
  .RAMP_ENA_O(RAMP_ENA_O),
  .LN4_DIS_RATE_O(LN4_DIS_RATE_O),
  .HP1_DIS_RATE_O(HP1_DIS_RATE_O),
  .LEFT_AMP_ENA_O(LEFT_AMP_ENA_O),
  .LEFT_AMP_MUTE_O(LEFT_AMP_MUTE_O),
  .LEFT_MIX_CONNECT_O(LEFT_MIX_CONNECT_O),
  .LEFT_GAIN_O(LEFT_GAIN_O),
  .RIGHT_GAIN_O(RIGHT_GAIN_O)
);
`default_nettype wire

//--- aig_regs_test.sv
// self-checking bench for the anti-pop and input gain bank
`timescale 1ns/1ps
`default_nettype none
module aig_regs_test;
  logic CLK_I, RST_I, REG_WR_I, REG_RD_I, ZC_LEFT_I, ZC_RIGHT_I, REG_RVALID_O;
  logic [7:0] REG_ADDR_I;
  logic [15:0] REG_WDATA_I, REG_RDATA_O;
  logic [1:0] RAMP_SPEED_O, LN4_DIS_RATE_O, LN3_DIS_RATE_O, HP2_DIS_RATE_O, HP1_DIS_RATE_O;
  logic RAMP_ENA_O, LN4_DIS_ENA_O, LN3_DIS_ENA_O, HP2_DIS_ENA_O, HP1_DIS_ENA_O;
  logic LEFT_AMP_ENA_O, LEFT_AMP_MUTE_O, LEFT_MIX_CONNECT_O;
  logic RIGHT_AMP_ENA_O, RIGHT_AMP_MUTE_O, RIGHT_MIX_CONNECT_O;
  logic [5:0] LEFT_GAIN_O, RIGHT_GAIN_O;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  aig_regs DUT (
    .CLK_I(CLK_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O), .ZC_LEFT_I(ZC_LEFT_I), .ZC_RIGHT_I(ZC_RIGHT_I),
    .RAMP_SPEED_O(RAMP_SPEED_O), .RAMP_ENA_O(RAMP_ENA_O),
    .LN4_DIS_RATE_O(LN4_DIS_RATE_O), .LN4_DIS_ENA_O(LN4_DIS_ENA_O),
    .LN3_DIS_RATE_O(LN3_DIS_RATE_O), .LN3_DIS_ENA_O(LN3_DIS_ENA_O),
    .HP2_DIS_RATE_O(HP2_DIS_RATE_O), .HP2_DIS_ENA_O(HP2_DIS_ENA_O),
    .HP1_DIS_RATE_O(HP1_DIS_RATE_O), .HP1_DIS_ENA_O(HP1_DIS_ENA_O),
    .LEFT_AMP_ENA_O(LEFT_AMP_ENA_O), .LEFT_AMP_MUTE_O(LEFT_AMP_MUTE_O),
    .LEFT_MIX_CONNECT_O(LEFT_MIX_CONNECT_O), .LEFT_GAIN_O(LEFT_GAIN_O),
    .RIGHT_AMP_ENA_O(RIGHT_AMP_ENA_O), .RIGHT_AMP_MUTE_O(RIGHT_AMP_MUTE_O),
    .RIGHT_MIX_CONNECT_O(RIGHT_MIX_CONNECT_O), .RIGHT_GAIN_O(RIGHT_GAIN_O)
  );
  // clock, 25 ns period
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  // compare one value and count it
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one-cycle write strobe, outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_I);
    REG_WR_I <= 1'b1;
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
    #1;
  endtask
  // one-cycle read strobe, answer looked at in its one valid cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge CLK_I);
    REG_RD_I <= 1'b1;
    REG_ADDR_I <= a;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    #1;
    chk("rvalid", REG_RVALID_O, 16'h0001);
    chk("rdata", REG_RDATA_O, e);
  endtask
  // one-cycle crossing pulses
  task automatic zc(input logic l, input logic r);
    @(posedge CLK_I);
    ZC_LEFT_I <= l;
    ZC_RIGHT_I <= r;
    @(posedge CLK_I);
    ZC_LEFT_I <= 1'b0;
    ZC_RIGHT_I <= 1'b0;
    #1;
  endtask
  // hang guard, far above the roughly 85 cycles needed
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  // main sequence
  initial begin
    logic [9:0] f;
    RST_I = 1'b1;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    REG_ADDR_I = 8'h00;
    REG_WDATA_I = 16'h0000;
    ZC_LEFT_I = 1'b0;
    ZC_RIGHT_I = 1'b0;
    repeat (12) @(posedge CLK_I);
    RST_I <= 1'b0;
    // reset values
    chk("gains", {LEFT_GAIN_O, RIGHT_GAIN_O}, 16'h0410);
    chk("enas", {LEFT_AMP_ENA_O, RIGHT_AMP_ENA_O, RAMP_ENA_O}, 16'h0000);
    rd(8'h4E, 16'h0000);
    rd(8'h50, 16'h0040);
    rd(8'h51, 16'h0040);
    // every code in every anti-pop field, high bits ignored
    for (int c = 0; c < 4; c++) begin
      f = {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3), 2'(c)};
      wr(8'h4E, {6'h3F, f});
      chk("rates", {RAMP_SPEED_O, LN4_DIS_RATE_O, LN3_DIS_RATE_O,
          HP2_DIS_RATE_O, HP1_DIS_RATE_O}, 16'(f));
      chk("rate_ena", {RAMP_ENA_O, LN4_DIS_ENA_O, LN3_DIS_ENA_O,
          HP2_DIS_ENA_O, HP1_DIS_ENA_O}, {f[9:8] != 0, f[7:6] != 0, f[5:4] != 0,
          f[3:2] != 0, f[1:0] != 0});
      rd(8'h4E, 16'(f));
    end
    // unmapped places read zero and take no write
    wr(8'h52, 16'hFFFF);
    rd(8'h4F, 16'h0000);
    rd(8'h4E, 16'(f));
    // enable and mute, both channels
    wr(8'h50, 16'hC040);
    wr(8'h51, 16'h4040);
    chk("ena_mute", {LEFT_AMP_ENA_O, LEFT_AMP_MUTE_O, LEFT_MIX_CONNECT_O,
        RIGHT_AMP_ENA_O, RIGHT_AMP_MUTE_O, RIGHT_MIX_CONNECT_O}, 16'h0032);
    wr(8'h50, 16'h8040);
    wr(8'h51, 16'h8040);
    chk("connect", {LEFT_MIX_CONNECT_O, RIGHT_MIX_CONNECT_O,
        RIGHT_AMP_MUTE_O}, 16'h0006);
    // gain pends until a trigger on either register
    wr(8'h50, 16'h80FC);
    chk("pend", {LEFT_GAIN_O, RIGHT_GAIN_O}, 16'h0410);
    rd(8'h50, 16'h80FC);
    wr(8'h51, 16'h8100);
    chk("apply", {LEFT_GAIN_O, RIGHT_GAIN_O}, 16'h0FC0);
    rd(8'h51, 16'h8000);
    // left waits for its crossing, right applies at once
    wr(8'h50, 16'hA044);
    wr(8'h51, 16'h8180);
    repeat (3) @(posedge CLK_I);
    chk("zc_wait", {LEFT_GAIN_O, RIGHT_GAIN_O}, 16'h0FE0);
    zc(1'b0, 1'b1);
    chk("zc_other", LEFT_GAIN_O, 16'h003F);
    zc(1'b1, 1'b0);
    chk("zc_left", LEFT_GAIN_O, 16'h0011);
    // right deferred to its own crossing
    wr(8'h51, 16'hA114);
    chk("zc_r_wait", RIGHT_GAIN_O, 16'h0020);
    zc(1'b0, 1'b1);
    chk("zc_right", RIGHT_GAIN_O, 16'h0005);
    zc(1'b0, 1'b1);
    chk("zc_unarmed", RIGHT_GAIN_O, 16'h0005);
    // a trigger while waiting re-arms; clearing zero cross releases it
    wr(8'h50, 16'hA1A8);
    chk("zc_rearm", LEFT_GAIN_O, 16'h0011);
    wr(8'h50, 16'h80A8);
    @(posedge CLK_I);
    #1;
    chk("zc_release", LEFT_GAIN_O, 16'h002A);
    // trigger and crossing on one edge apply the fresh gain at once
    @(posedge CLK_I);
    REG_WR_I <= 1'b1;
    REG_ADDR_I <= 8'h51;
    REG_WDATA_I <= 16'hA1F0;
    ZC_RIGHT_I <= 1'b1;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
    ZC_RIGHT_I <= 1'b0;
    #1;
    chk("zc_same_edge", {LEFT_GAIN_O, RIGHT_GAIN_O}, 16'h0ABC);
    // reset again in mid-run: gains and readback return to defaults
    RST_I <= 1'b1;
    @(posedge CLK_I);
    RST_I <= 1'b0;
    #1;
    chk("rst_gains", {LEFT_GAIN_O, RIGHT_GAIN_O}, 16'h0410);
    rd(8'h50, 16'h0040);
    close_out();
  end
endmodule
`default_nettype wire
